// ===== src/rsq_defines.vh
// Purpose: constants for the reset sequencer with cause flags
// Assumes: 125 MHz reference clock, AXI4-Lite register access
// Notes: all counts are reference clock cycles
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH

// ***************************************
// timing
// ***************************************
`define RSQ_CLK_PERIOD_NS 8
`define RSQ_EXT_MIN_LOW_NS 125
`define RSQ_EXT_MIN_LOW_CYC ((`RSQ_EXT_MIN_LOW_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)
`define RSQ_STAB_CYC 4096
`define RSQ_PIN_LOW_CYC 32
`define RSQ_CORE_HOLD_CYC 32
`define RSQ_BUS_DIV 4

// ***************************************
// register offsets
// ***************************************
`define RSQ_CAUSE_OFS 8'h00
`define RSQ_CTRL_OFS 8'h04
`define RSQ_STATE_OFS 8'h08

// ***************************************
// cause register fields and reset values
// ***************************************
`define RSQ_F_POR 7
`define RSQ_F_PIN 6
`define RSQ_F_WDOG 5
`define RSQ_F_BADOP 4
`define RSQ_F_BADADR 3
`define RSQ_F_MON 2
`define RSQ_F_LOWV 1
`define RSQ_CAUSE_RST 8'h80
`define RSQ_CTRL_RST 8'h00

// ***************************************
// control fields and vectors
// ***************************************
`define RSQ_C_STOPEN 0
`define RSQ_C_MONMODE 1
`define RSQ_VEC_HI_NORM 16'hFFFE
`define RSQ_VEC_HI_MON 16'hFEFE
`define RSQ_VEC_LO 16'hFFFF
`define RSQ_WDOG_ADDR 16'hFFFF
`define RSQ_RESP_OKAY 2'b00
`define RSQ_RESP_SLVERR 2'b10

`endif

// ===== src/rsq_reset_sequencer.v
// Purpose: reset sequencing, reset pin drive and reset cause flags
// Assumes: inputs synchronous to sys_clk except the reset pin input
// Notes: the reset pin is open drain; oe high pulls it low
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"

module rsq_reset_sequencer (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // open-drain reset pin
   input wire rstPinIn,
   output reg rstPinOut,
   output reg rstPinOe,
   // reset sources
   input wire powerOnPulse,
   input wire watchdogOverflow,
   input wire supplyBelowTrip,
   input wire monitorEntryReq,
   // core fetch monitor
   input wire opFetch,
   input wire opIllegal,
   input wire opIsStop,
   input wire fetchUnmapped,
   // core write monitor
   input wire cpuWrite,
   input wire [15:0] cpuAddr,
   // core and clock control
   output reg coreReset,
   output reg abortInstr,
   output reg clocksHold,
   output reg busClkDivFour,
   output reg watchdogClear,
   output reg [15:0] vecHiAddr,
   output reg [15:0] vecLoAddr
);

   // ***************************************
   // states
   // ***************************************
   localparam ST_IDLE = 3'd0;
   localparam ST_LOWV = 3'd1;
   localparam ST_STAB = 3'd2;
   localparam ST_PINLOW = 3'd3;
   localparam ST_HOLD = 3'd4;
   localparam ST_EXT = 3'd5;

   // ***************************************
   // declarations
   // ***************************************
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [12:0] cnt_reg;
   reg [12:0] cnt_next;
   reg intSeq_reg;
   reg intSeq_next;
   reg pinMeta_reg;
   reg pinSync_reg;
   reg [4:0] lowCnt_reg;
   reg [7:0] cause_reg;
   reg [7:0] cause_next;
   reg [7:0] ctrl_reg;
   reg awHave_reg;
   reg wHave_reg;
   reg [7:0] awAddr_reg;
   reg [31:0] wData_reg;
   reg [3:0] wStrb_reg;
   wire readClear;
   wire badOpReq;
   wire badAdrReq;
   wire intReq;
   wire extLowMet;
   wire pinLowSync;

   // ***************************************
   // request decode
   // ***************************************
   // only opcode fetches qualify, plain data accesses never reset
   assign badOpReq = opFetch & (opIllegal | (opIsStop & ~ctrl_reg[`RSQ_C_STOPEN]));
   assign badAdrReq = opFetch & fetchUnmapped;
   assign intReq = watchdogOverflow | badOpReq | badAdrReq | monitorEntryReq;
   assign pinLowSync = ~pinSync_reg;
   // clear in the very cycle the cause word is captured, so no later event is lost
   assign readClear = s_axi_arvalid & s_axi_arready & (s_axi_araddr[7:2] == `RSQ_CAUSE_OFS >> 2);
   assign extLowMet = (lowCnt_reg >= `RSQ_EXT_MIN_LOW_CYC);

   // counts end on the last cycle of a phase
   function cntDone;
      input [12:0] c;
      input [12:0] len;
      begin
         cntDone = (c == len - 13'd1);
      end
   endfunction

   // ***************************************
   // reset pin synchroniser and low timer
   // ***************************************
   // two flops before any use of the pin level
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinMeta_reg <= 1'b1;
         pinSync_reg <= 1'b1;
      end else begin
         pinMeta_reg <= rstPinIn;
         pinSync_reg <= pinMeta_reg;
      end
   end

   // measure low time of the pin while we do not drive it
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lowCnt_reg <= 5'h00;
      end else if (~pinLowSync | rstPinOe) begin
         lowCnt_reg <= 5'h00;
      end else if (~extLowMet) begin
         lowCnt_reg <= lowCnt_reg + 5'h01;
      end
   end

   // ***************************************
   // sequencer next state
   // ***************************************
   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg + 13'd1;
      intSeq_next = intSeq_reg;
      if (powerOnPulse) begin
         state_next = ST_STAB;
         cnt_next = 13'd0;
         intSeq_next = 1'b1;
      end else if (supplyBelowTrip) begin
         state_next = ST_LOWV;
         cnt_next = 13'd0;
         intSeq_next = 1'b1;
      end else if (intReq && state_reg != ST_STAB && state_reg != ST_LOWV) begin
         state_next = ST_PINLOW;
         cnt_next = 13'd0;
         intSeq_next = 1'b1;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               cnt_next = 13'd0;
               if (extLowMet) begin
                  state_next = ST_EXT;
                  intSeq_next = 1'b0;
               end
            end
            ST_LOWV: begin
               state_next = ST_STAB; // supply back above trip
               cnt_next = 13'd0;
            end
            ST_STAB: begin
               if (cntDone(cnt_reg, 13'd`RSQ_STAB_CYC)) begin
                  state_next = ST_PINLOW;
                  cnt_next = 13'd0;
               end
            end
            ST_PINLOW: begin
               if (cntDone(cnt_reg, 13'd`RSQ_PIN_LOW_CYC)) begin
                  state_next = ST_HOLD;
                  cnt_next = 13'd0;
               end
            end
            ST_HOLD: begin
               if (cntDone(cnt_reg, 13'd`RSQ_CORE_HOLD_CYC)) begin
                  state_next = ST_IDLE;
                  cnt_next = 13'd0;
               end
            end
            ST_EXT: begin
               cnt_next = 13'd0;
               if (~pinLowSync) begin
                  state_next = ST_IDLE;
               end
            end
            default: begin
               state_next = ST_IDLE;
               cnt_next = 13'd0;
            end
         endcase
      end
   end

   // ***************************************
   // sequencer registers and core controls
   // ***************************************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_STAB;
         cnt_reg <= 13'd0;
         intSeq_reg <= 1'b1;
         rstPinOut <= 1'b0;
         rstPinOe <= 1'b1;
         coreReset <= 1'b1;
         abortInstr <= 1'b1;
         clocksHold <= 1'b1;
         busClkDivFour <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         intSeq_reg <= intSeq_next;
         rstPinOut <= 1'b0;
         // pin pulled low during low supply, delay and pin-low phases
         rstPinOe <= (state_next == ST_LOWV) | (state_next == ST_STAB) | (state_next == ST_PINLOW);
         // core held from the request until the hold phase ends, or for a pin reset until the pin goes high
         coreReset <= (state_next != ST_IDLE);
         abortInstr <= (state_next != ST_IDLE) & (state_reg == ST_IDLE);
         clocksHold <= (state_next == ST_LOWV) | (state_next == ST_STAB);
         if (state_next != ST_IDLE) begin
            busClkDivFour <= 1'b1;
         end
      end
   end

   // ***************************************
   // vector address and watchdog service
   // ***************************************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vecHiAddr <= `RSQ_VEC_HI_NORM;
         vecLoAddr <= `RSQ_VEC_LO;
         watchdogClear <= 1'b0;
      end else begin
         vecHiAddr <= ctrl_reg[`RSQ_C_MONMODE] ? `RSQ_VEC_HI_MON : `RSQ_VEC_HI_NORM;
         vecLoAddr <= `RSQ_VEC_LO;
         watchdogClear <= cpuWrite & (cpuAddr == `RSQ_WDOG_ADDR);
      end
   end

   // ***************************************
   // reset cause flags
   // ***************************************
   // read clears first, new events then set, so a set wins
   always @* begin
      cause_next = cause_reg;
      if (readClear) begin
         cause_next = 8'h00;
      end
      if (watchdogOverflow) begin
         cause_next[`RSQ_F_WDOG] = 1'b1;
      end
      if (badOpReq) begin
         cause_next[`RSQ_F_BADOP] = 1'b1;
      end
      if (badAdrReq) begin
         cause_next[`RSQ_F_BADADR] = 1'b1;
      end
      if (monitorEntryReq) begin
         cause_next[`RSQ_F_MON] = 1'b1;
      end
      if (supplyBelowTrip) begin
         cause_next[`RSQ_F_LOWV] = 1'b1;
      end
      if (state_reg == ST_IDLE && extLowMet) begin
         cause_next[`RSQ_F_PIN] = 1'b1;
      end
      // pin still low at the end of the hold phase
      if (state_reg == ST_HOLD && intSeq_reg && pinLowSync
          && cntDone(cnt_reg, 13'd`RSQ_CORE_HOLD_CYC)) begin
         cause_next[`RSQ_F_PIN] = 1'b1;
      end
      if (powerOnPulse) begin
         cause_next = `RSQ_CAUSE_RST;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cause_reg <= `RSQ_CAUSE_RST;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // ***************************************
   // axi4-lite write channel
   // ***************************************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         awHave_reg <= 1'b0;
         wHave_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RSQ_RESP_OKAY;
         ctrl_reg <= `RSQ_CTRL_RST;
      end else begin
         s_axi_awready <= ~awHave_reg & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~wHave_reg & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         // both halves held: perform write and answer
         if (awHave_reg & wHave_reg & ~s_axi_bvalid) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_reg[7:2] == `RSQ_CTRL_OFS >> 2) begin
               s_axi_bresp <= `RSQ_RESP_OKAY;
               if (wStrb_reg[0]) begin
                  ctrl_reg <= wData_reg[7:0];
               end
            end else if (awAddr_reg[7:2] == `RSQ_CAUSE_OFS >> 2
                         || awAddr_reg[7:2] == `RSQ_STATE_OFS >> 2) begin
               s_axi_bresp <= `RSQ_RESP_OKAY; // read-only, write ignored
            end else begin
               s_axi_bresp <= `RSQ_RESP_SLVERR;
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ***************************************
   // axi4-lite read channel
   // ***************************************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RSQ_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RSQ_RESP_OKAY;
            case (s_axi_araddr[7:2])
               `RSQ_CAUSE_OFS >> 2: begin
                  s_axi_rdata <= {24'h00_0000, cause_reg};
               end
               `RSQ_CTRL_OFS >> 2: begin
                  s_axi_rdata <= {24'h00_0000, ctrl_reg};
               end
               `RSQ_STATE_OFS >> 2: begin
                  s_axi_rdata <= {26'h000_0000, pinSync_reg, coreReset, clocksHold, state_reg};
               end
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RSQ_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // rsq_reset_sequencer
`default_nettype wire

// ===== testbench/rsq_pin_partner.sv
// Purpose: far-side device that pulls the shared reset line
// Assumes: the line has a pull-up in the bench
// Notes: pull length is set per command
`timescale 1ns/1ps
`default_nettype none
module rsq_pin_partner (
   // clock
   input wire logic sys_clk,
   // command
   input wire logic start,
   input wire logic [7:0] lowCycles,
   // line drive
   output logic pullLow
);
   logic [7:0] cnt = 8'h00;
   // hold the line low for the commanded count
   always @(posedge sys_clk) begin
      if (start) begin
         cnt <= lowCycles;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end
   assign pullLow = (cnt != 8'h00);
endmodule // rsq_pin_partner
`default_nettype wire

// ===== testbench/rsq_seq_props.sv
// Purpose: port checker for the reset sequencer
// Assumes: one clock, async active high reset
// Notes: counts are sys_clk cycles
`timescale 1ns/1ps
`default_nettype none
module rsq_seq_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // sources
   input wire logic watchdogOverflow,
   input wire logic supplyBelowTrip,
   input wire logic opFetch,
   input wire logic opIllegal,
   input wire logic fetchUnmapped,
   input wire logic cpuWrite,
   input wire logic [15:0] cpuAddr,
   // sequencer outputs
   input wire logic rstPinOe,
   input wire logic coreReset,
   input wire logic abortInstr,
   input wire logic clocksHold,
   input wire logic busClkDivFour,
   input wire logic watchdogClear
);
   logic [12:0] pinCnt;
   logic [12:0] stabCnt;
   // run lengths of pin drive after hold, and of clock hold
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinCnt <= 13'h0000;
         stabCnt <= 13'h0000;
      end else begin
         pinCnt <= (rstPinOe && !clocksHold) ? pinCnt + 13'h0001 : 13'h0000;
         stabCnt <= (supplyBelowTrip || !clocksHold) ? 13'h0000 : stabCnt + 13'h0001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_abort; $rose(coreReset) |-> abortInstr; endproperty
   a_abort: assert property (p_abort) else $error("abort missing");
   property p_div; coreReset |-> busClkDivFour; endproperty
   a_div: assert property (p_div) else $error("bus clock not divided");
   property p_src; (watchdogOverflow || (opFetch && (opIllegal || fetchUnmapped))) && !coreReset
      |=> coreReset && rstPinOe && !clocksHold; endproperty
   a_src: assert property (p_src) else $error("internal reset missing");
   property p_pin; $fell(rstPinOe) |-> pinCnt == 13'h0020; endproperty
   a_pin: assert property (p_pin) else $error("pin drive length wrong");
   property p_hold; $fell(rstPinOe) |-> ##31 coreReset ##1 !coreReset; endproperty
   a_hold: assert property (p_hold) else $error("core hold length wrong");
   property p_stab; $fell(clocksHold) |-> stabCnt >= 13'h0FFF && stabCnt <= 13'h1001; endproperty
   a_stab: assert property (p_stab) else $error("stabilisation length wrong");
   property p_low; supplyBelowTrip |=> rstPinOe && clocksHold && coreReset; endproperty
   a_low: assert property (p_low) else $error("low supply not held");
   property p_wclr; cpuWrite && cpuAddr == 16'hFFFF |=> watchdogClear; endproperty
   a_wclr: assert property (p_wclr) else $error("watchdog clear missing");
   property p_data; fetchUnmapped && !opFetch && !coreReset && !watchdogOverflow |=> !coreReset; endproperty
   a_data: assert property (p_data) else $error("data access reset");
   c_int: cover property ($fell(rstPinOe));
   c_ext: cover property ($rose(coreReset) && !rstPinOe);
   c_stab: cover property ($fell(clocksHold));
endmodule // rsq_seq_props
bind rsq_reset_sequencer rsq_seq_props u_props (.sys_clk, .rst, .watchdogOverflow, .supplyBelowTrip,
   .opFetch, .opIllegal, .fetchUnmapped, .cpuWrite, .cpuAddr, .rstPinOe, .coreReset, .abortInstr,
   .clocksHold, .busClkDivFour, .watchdogClear);
`default_nettype wire

// ===== testbench/tb_reset_sequencer_with_cause_flags.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: pulled-up open-drain reset line
// Notes: each scenario judges its own results
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"
module tb_reset_sequencer_with_cause_flags;
   // ****
   // stimulus and wiring
   // ****
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [6:0] ev = 7'h00;
   logic supplyBelowTrip = 1'b0;
   logic cpuWrite = 1'b0;
   logic [15:0] cpuAddr = 16'h0000;
   logic pStart = 1'b0;
   logic [7:0] pLow = 8'h00;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire rstPinOut, rstPinOe, pullLow, coreReset, abortInstr, clocksHold, busClkDivFour, watchdogClear;
   wire [15:0] vecHiAddr, vecLoAddr;
   // shared reset line with pull-up
   wire rstPinIn = !((rstPinOe && !rstPinOut) || pullLow);
   int error_cnt = 0;
   int checks_done = 0;
   // bench clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   rsq_reset_sequencer DUT (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .rstPinIn, .rstPinOut, .rstPinOe, .powerOnPulse(ev[6]), .watchdogOverflow(ev[0]),
      .supplyBelowTrip, .monitorEntryReq(ev[1]), .opFetch(ev[2]), .opIllegal(ev[3]), .opIsStop(ev[4]),
      .fetchUnmapped(ev[5]), .cpuWrite, .cpuAddr, .coreReset, .abortInstr, .clocksHold, .busClkDivFour,
      .watchdogClear, .vecHiAddr, .vecLoAddr);
   rsq_pin_partner u_partner (.sys_clk, .start(pStart), .lowCycles(pLow), .pullLow);
   // ****
   // shared tasks
   // ****
   task report_and_stop;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tmo;
      chk(32'h0, 32'h1);
      report_and_stop;
   endtask
   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (n == 50) tmo;
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd_exp(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (n == 50) tmo;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
   endtask
   // count pin drive and core hold cycles until the core is released
   task measure(input int eo, input int ec);
      int no, nc, n;
      no = 0;
      nc = 0;
      for (n = 0; n < 6000; n++) begin
         @(negedge sys_clk);
         if (coreReset !== 1'b1) break;
         nc++;
         if (rstPinOe === 1'b1) no++;
      end
      if (n == 6000) tmo;
      chk(no, eo);
      chk(nc, ec);
   endtask
   task fire(input logic [6:0] v, input int eo, input int ec);
      @(posedge sys_clk);
      ev <= v;
      @(posedge sys_clk);
      ev <= 7'h00;
      measure(eo, ec);
   endtask
   task pulse_pin(input logic [7:0] len, output int n);
      @(posedge sys_clk);
      pLow <= len;
      pStart <= 1'b1;
      @(posedge sys_clk);
      pStart <= 1'b0;
      for (n = 0; n < 40 && coreReset !== 1'b1; n++) @(negedge sys_clk);
   endtask
   // ****
   // scenarios
   // ****
   task t_por;
      measure(4096 + 32, 4096 + 64);
      chk(busClkDivFour, 1'b1);
      rd_exp(`RSQ_CAUSE_OFS, 32'h80, `RSQ_RESP_OKAY);
      rd_exp(`RSQ_CAUSE_OFS, 32'h0, `RSQ_RESP_OKAY);
   endtask
   task t_regs;
      logic [1:0] r;
      axi_wr(`RSQ_CTRL_OFS, 32'h2, r);
      @(negedge sys_clk);
      chk(vecHiAddr, `RSQ_VEC_HI_MON);
      chk(vecLoAddr, `RSQ_VEC_LO);
      axi_wr(`RSQ_CAUSE_OFS, 32'hFF, r);
      rd_exp(`RSQ_CAUSE_OFS, 32'h0, `RSQ_RESP_OKAY);
      axi_wr(8'h10, 32'h0, r);
      chk(r, `RSQ_RESP_SLVERR);
      rd_exp(8'h10, 32'h0, `RSQ_RESP_SLVERR);
      axi_wr(`RSQ_CTRL_OFS, 32'h0, r);
      @(negedge sys_clk);
      chk(vecHiAddr, `RSQ_VEC_HI_NORM);
   endtask
   task t_wdog;
      @(posedge sys_clk);
      cpuWrite <= 1'b1;
      cpuAddr <= `RSQ_WDOG_ADDR;
      @(posedge sys_clk);
      cpuWrite <= 1'b0;
      @(negedge sys_clk);
      chk(watchdogClear, 1'b1);
      fire(7'h01, 32, 64);
      rd_exp(`RSQ_CAUSE_OFS, 32'h20, `RSQ_RESP_OKAY);
   endtask
   task t_faults;
      logic [1:0] r;
      fire(7'h20, 0, 0);
      fire(7'h0C, 32, 64);
      fire(7'h24, 32, 64);
      rd_exp(`RSQ_CAUSE_OFS, 32'h18, `RSQ_RESP_OKAY);
      fire(7'h14, 32, 64);
      rd_exp(`RSQ_CAUSE_OFS, 32'h10, `RSQ_RESP_OKAY);
      axi_wr(`RSQ_CTRL_OFS, 32'h1, r);
      fire(7'h14, 0, 0);
      fire(7'h02, 32, 64);
      rd_exp(`RSQ_CAUSE_OFS, 32'h04, `RSQ_RESP_OKAY);
   endtask
   task t_ext;
      int n;
      pulse_pin(8'h08, n);
      chk(n, 40);
      pulse_pin(8'h14, n);
      chk(coreReset, 1'b1);
      chk(rstPinOe, 1'b0);
      for (n = 0; n < 100 && coreReset === 1'b1; n++) @(negedge sys_clk);
      chk(coreReset, 1'b0);
      rd_exp(`RSQ_CAUSE_OFS, 32'h40, `RSQ_RESP_OKAY);
   endtask
   task t_lowv;
      @(posedge sys_clk);
      supplyBelowTrip <= 1'b1;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(rstPinOe && clocksHold, 1'b1);
      @(posedge sys_clk);
      supplyBelowTrip <= 1'b0;
      measure(1 + 4096 + 32, 1 + 4096 + 64);
      rd_exp(`RSQ_CAUSE_OFS, 32'h02, `RSQ_RESP_OKAY);
   endtask
   task t_porp;
      fire(7'h01, 32, 64);
      fire(7'h40, 4096 + 32, 4096 + 64);
      rd_exp(`RSQ_CAUSE_OFS, 32'h80, `RSQ_RESP_OKAY);
   endtask
   // main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_por;
      t_regs;
      t_wdog;
      t_faults;
      t_ext;
      t_lowv;
      t_porp;
      report_and_stop;
   end
endmodule // tb_reset_sequencer_with_cause_flags
`default_nettype wire
